// ===== src/ldc_pkg.sv
// constants, field layout and carriers for the led driver register bank
package ldc_pkg;
  // serial bus address and register indices
  localparam logic [6:0] LDC_BUS_ADDR = 7'h38;
  localparam logic [7:0] LDC_IDX_CHAN_CFG = 8'h01;
  localparam logic [7:0] LDC_IDX_FAULT = 8'h02;
  localparam logic [7:0] LDC_IDX_IDENT = 8'h03;
  // arbitrary neutral identity value, not tied to any real part
  localparam logic [7:0] LDC_IDENT_DEFAULT = 8'h5a;
  // field positions
  localparam int LDC_PSE_BIT = 7;
  localparam int LDC_THR_LSB = 5;
  localparam int LDC_FSW_LSB = 3;
  localparam int LDC_CH_LSB = 0;
  localparam int LDC_SEN_BIT = 7;
  localparam int LDC_COMP_SAT_TIME_SEL_BIT = 6;
  localparam int LDC_FLAG_MSB = 5;
  // reset values
  localparam logic [7:0] LDC_CHAN_CFG_RESET = 8'h28;
  localparam logic [1:0] LDC_FAULT_CTL_RESET = 2'h0;
  localparam logic [5:0] LDC_FLAGS_RESET = 6'h00;
  localparam int LDC_NUM_CHANNELS = 6;
  // comp saturation timing
  localparam longint LDC_CLOCK_HZ = 20_000_000;
  localparam longint LDC_COMP_SAT_SHORT_MS = 20;
  localparam longint LDC_COMP_SAT_LONG_MS = 40;
  localparam int LDC_COMP_SAT_SHORT_CYC = int'(LDC_COMP_SAT_SHORT_MS * LDC_CLOCK_HZ / 1000);
  localparam int LDC_COMP_SAT_LONG_CYC = int'(LDC_COMP_SAT_LONG_MS * LDC_CLOCK_HZ / 1000);

  // channel config register layout
  typedef struct packed {
    logic phase_shift_enable;
    logic [1:0] short_threshold_sel;
    logic [1:0] switch_osc_program_pin_sel;
    logic [2:0] active_channel_count;
  } ldc_chan_cfg_t;

  // protection events from the analog side, one bit each
  typedef struct packed {
    logic over_temp;
    logic output_undervolt;
    logic overcurrent;
    logic sink_short;
    logic sink_open;
  } ldc_fault_events_t;

  // serial slave states
  typedef enum logic [3:0] {
    LDC_IDLE,
    LDC_ADDR,
    LDC_ADDR_ACK,
    LDC_INDEX,
    LDC_INDEX_ACK,
    LDC_WRITE,
    LDC_WRITE_ACK,
    LDC_READ,
    LDC_READ_ACK
  } ldc_state_t;
endpackage : ldc_pkg

// ===== src/ldc_regs.sv
// serial-bus register bank: configuration, sticky faults and identity
// What this block does
// - bit 7 at 0x01 enables phase shift
// - bits 6:5 pick short threshold, reset 01
// - bits 4:3 pick switching frequency, reset 01
// - bits 2:0 choose active channels, reset 000
// - bit 7 at 0x02 enables all-short protection
// - bit 6 picks 20 or 40 ms
// - bit 5 latches led-to-ground short fault
// - bit 4 latches over-temperature fault
// - bit 3 latches output under-voltage fault
// - bit 2 latches over-current fault
// - bit 1 latches sink short fault
// - bit 0 latches sink open fault
// - fault bits clear after being read
// - 0x03 is fixed read-only identity
// - answer at bus address 0x38, r/w bit
`timescale 1ns/1ps
module ldc_regs
  import ldc_pkg::*;
#(
  parameter int COMP_SAT_SHORT_CYC = ldc_pkg::LDC_COMP_SAT_SHORT_CYC, // 20 ms in clocks
  parameter int COMP_SAT_LONG_CYC = ldc_pkg::LDC_COMP_SAT_LONG_CYC, // 40 ms in clocks
  parameter logic [7:0] IDENT_VALUE = ldc_pkg::LDC_IDENT_DEFAULT // arbitrary id
)
(
  input wire logic clock, // 20 mhz system clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic scl, // serial clock pin level
  input wire logic sda_in, // serial data pin level
  output logic sda_out, // serial data drive value, always low
  output logic sda_oe, // pull data low while high
  input wire ldc_pkg::ldc_fault_events_t fault_events, // protection events
  input wire logic comp_saturated, // comp node at saturation
  input wire logic duty_above_2pct, // dimming duty exceeds 2 percent
  output ldc_pkg::ldc_chan_cfg_t chan_cfg, // live channel config fields
  output logic [5:0] channel_enable, // per-channel enable, bit 0 = led1
  output logic all_short_protect_active, // all-short protection armed
  output logic comp_sat_time_sel, // 0: 20 ms, 1: 40 ms
  output logic led_ground_trip, // one-cycle ground short detect
  output logic [5:0] fault_flags // sticky fault bits 5:0
);
  localparam int CW = $clog2(COMP_SAT_LONG_CYC + 1);

  // ack slots in which the slave, not the host, owns the data line
  function automatic logic slave_ack_slot(input ldc_state_t s);
    return (s == LDC_ADDR_ACK) || (s == LDC_INDEX_ACK) || (s == LDC_WRITE_ACK);
  endfunction : slave_ack_slot

  // channel code to enable mask; reserved codes enable nothing
  function automatic logic [5:0] chan_mask(input logic [2:0] code);
    logic [5:0] m;
    m = 6'h00;
    if (code <= 3'h5)
      m = 6'h3f >> code;
    return m;
  endfunction : chan_mask

  ldc_state_t state;
  ldc_state_t next_state;
  logic scl_prev;
  logic sda_prev;
  logic [3:0] bit_cnt;
  logic [7:0] shift_in;
  logic [7:0] shift_out;
  logic [7:0] reg_index;
  logic read_dir;
  logic master_ack_q;
  logic all_short_protect_enable;
  logic [CW-1:0] comp_cnt;

  // bus edge events; inputs already synchronous, one stage for history
  wire scl_rise = scl & ~scl_prev;
  wire scl_fall = ~scl & scl_prev;
  wire start_cond = scl & scl_prev & sda_prev & ~sda_in;
  wire stop_cond = scl & scl_prev & ~sda_prev & sda_in;
  wire byte_done = (bit_cnt == 4'h8);
  wire addr_match = (shift_in[7:1] == LDC_BUS_ADDR);
  wire master_ack = ~sda_in;
  wire in_slave_ack = slave_ack_slot(state);

  // read data selection; unmapped indices read zero
  wire [7:0] fault_view = {all_short_protect_enable, comp_sat_time_sel, fault_flags};
  wire [7:0] read_data = (reg_index == LDC_IDX_CHAN_CFG) ? chan_cfg :
                         (reg_index == LDC_IDX_FAULT) ? fault_view :
                         (reg_index == LDC_IDX_IDENT) ? IDENT_VALUE : 8'h00;

  // a byte is handed to the host at these falls
  wire load_tx = scl_fall & ((state == LDC_ADDR_ACK & read_dir) |
                             (state == LDC_READ_ACK & master_ack_q));
  wire write_strobe = scl_fall & (state == LDC_WRITE) & byte_done;
  wire wr_chan = write_strobe & (reg_index == LDC_IDX_CHAN_CFG);
  wire wr_fault = write_strobe & (reg_index == LDC_IDX_FAULT);
  // clear only what the host actually saw, so a new event is kept
  wire [5:0] flag_clear = (load_tx & (reg_index == LDC_IDX_FAULT)) ? fault_flags : 6'h00;

  // comp saturation timer
  wire [CW-1:0] comp_target = comp_sat_time_sel ? CW'(COMP_SAT_LONG_CYC) :
                                                  CW'(COMP_SAT_SHORT_CYC);
  assign led_ground_trip = comp_saturated & (comp_cnt == comp_target - CW'(1));
  wire [5:0] fault_set = {led_ground_trip, fault_events};

  // live outputs
  assign channel_enable = chan_mask(chan_cfg.active_channel_count);
  assign all_short_protect_active = all_short_protect_enable & duty_above_2pct;
  assign sda_out = 1'b0;
  // open drain: ack slots and zero data bits pull low
  assign sda_oe = in_slave_ack | ((state == LDC_READ) & ~shift_out[7]);

  // slave state transitions: bit-level moves on scl falls so data is stable high; start and stop move it while scl is high
  always_comb
  begin
    next_state = state;
    if (scl_fall)
    begin
      unique case (state)
        // no start seen yet: ignore all bus clocks
        LDC_IDLE:
        begin
          next_state = LDC_IDLE;
        end
        // a foreign address sends us back to idle until the next start
        LDC_ADDR:
        begin
          if (byte_done)
            next_state = addr_match ? LDC_ADDR_ACK : LDC_IDLE;
        end
        LDC_ADDR_ACK:
        begin
          next_state = read_dir ? LDC_READ : LDC_INDEX;
        end
        LDC_INDEX:
        begin
          if (byte_done)
            next_state = LDC_INDEX_ACK;
        end
        LDC_INDEX_ACK:
        begin
          next_state = LDC_WRITE;
        end
        // data bytes keep coming until a stop or a repeated start
        LDC_WRITE:
        begin
          if (byte_done)
            next_state = LDC_WRITE_ACK;
        end
        LDC_WRITE_ACK:
        begin
          next_state = LDC_WRITE;
        end
        LDC_READ:
        begin
          if (byte_done)
            next_state = LDC_READ_ACK;
        end
        // a host nak ends the read, the line is then free for its stop
        LDC_READ_ACK:
        begin
          next_state = master_ack_q ? LDC_READ : LDC_IDLE;
        end
      endcase
    end
    // bus conditions override the bit-level moves
    if (start_cond)
      next_state = LDC_ADDR;
    else if (stop_cond)
      next_state = LDC_IDLE;
  end

  // pin history and state register
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
      state <= LDC_IDLE;
    end
    else
    begin
      scl_prev <= scl;
      sda_prev <= sda_in;
      state <= next_state;
    end
  end

  // bit counter: cleared at start, after each byte and after each ack slot
  always_ff @(posedge clock)
  begin
    if (!rst_n || start_cond || (scl_fall && (byte_done || in_slave_ack ||
        state == LDC_READ_ACK)))
      bit_cnt <= 4'h0;
    else if (scl_rise && !byte_done)
      bit_cnt <= bit_cnt + 4'h1;
  end

  // receive shifter, msb first; the ninth rise (the ack) is shifted in too, after the byte has been used at the eighth fall
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      shift_in <= 8'h00;
    else if (scl_rise && !byte_done)
      shift_in <= {shift_in[6:0], sda_in};
  end

  // direction bit, taken with the address byte
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      read_dir <= 1'b0;
    else if (scl_fall && state == LDC_ADDR && byte_done)
      read_dir <= shift_in[0];
  end

  // host acknowledge, sampled while scl is high in the ack slot
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      master_ack_q <= 1'b0;
    else if (scl_rise && state == LDC_READ_ACK)
      master_ack_q <= master_ack;
  end

  // transmit shifter; ones fill in so the line is released after the byte
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      shift_out <= 8'hff;
    else if (load_tx)
      shift_out <= read_data;
    else if (scl_fall && state == LDC_READ)
      shift_out <= {shift_out[6:0], 1'b1};
  end

  // register index: set by host, steps after each data byte
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      reg_index <= 8'h00;
    else if (scl_fall && state == LDC_INDEX && byte_done)
      reg_index <= shift_in;
    else if (write_strobe || load_tx)
      reg_index <= reg_index + 8'h01;
  end

  // channel configuration; reserved channel codes are stored as sent
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      chan_cfg <= ldc_chan_cfg_t'(LDC_CHAN_CFG_RESET);
    else if (wr_chan)
      chan_cfg <= ldc_chan_cfg_t'(shift_in);
  end

  // fault control bits; the flag bits of the same byte are read-only
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      {all_short_protect_enable, comp_sat_time_sel} <= LDC_FAULT_CTL_RESET;
    end
    else if (wr_fault)
    begin
      all_short_protect_enable <= shift_in[LDC_SEN_BIT];
      comp_sat_time_sel <= shift_in[LDC_COMP_SAT_TIME_SEL_BIT];
    end
  end

  // sticky fault flags; a set in the clearing cycle wins
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      fault_flags <= LDC_FLAGS_RESET;
    else
      fault_flags <= (fault_flags & ~flag_clear) | fault_set;
  end

  // saturation counter holds once the target is reached, one trip per episode
  always_ff @(posedge clock)
  begin
    if (!rst_n || !comp_saturated)
      comp_cnt <= '0;
    else if (comp_cnt < comp_target)
      comp_cnt <= comp_cnt + CW'(1);
  end
endmodule : ldc_regs

// ===== tb/ldc_host.sv
// serial host model for the register bank pins
`timescale 1ns/1ps
module ldc_host
  import ldc_pkg::*;
(
  input wire logic clock, // system clock
  input wire logic sda, // resolved data line
  output logic scl, // bus clock
  output logic sda_low // pull data low
);
  initial scl = 1'b1;
  initial sda_low = 1'b0;
  // set both pins, then wait n falling edges
  task automatic lines(input logic c, l, input int n);
    scl = c;
    sda_low = l;
    repeat (n) @(negedge clock);
  endtask : lines
  // data moves only while scl is low, so no false start or stop
  task automatic bit_io(input logic b, output logic r);
    lines(1'b0, !b, 3);
    lines(1'b1, !b, 3);
    r = sda;
    lines(1'b0, !b, 2);
  endtask : bit_io
  task automatic xfer(input logic [7:0] d, input logic m, output logic [7:0] q, output logic a);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], q[i]);
    bit_io(m, a);
  endtask : xfer
  // start, address with write bit, register index
  task automatic head(input logic [6:0] adr, input logic [7:0] idx, output logic a);
    logic [7:0] q;
    logic a1;
    lines(1'b1, 1'b0, 3);
    lines(1'b1, 1'b1, 3);
    lines(1'b0, 1'b1, 2);
    xfer({adr, 1'b0}, 1'b1, q, a);
    xfer(idx, 1'b1, q, a1);
    a = a | a1;
  endtask : head
  task automatic stop();
    lines(1'b1, 1'b1, 3);
    lines(1'b1, 1'b0, 3);
  endtask : stop
  // nak is high when any slot went unanswered
  task automatic wr(input logic [6:0] adr, input logic [7:0] idx, v, output logic nak);
    logic [7:0] q;
    logic a;
    head(adr, idx, nak);
    xfer(v, 1'b1, q, a);
    stop();
    nak = nak | a;
  endtask : wr
  // repeated start for the read, single byte closed by a nak
  task automatic rd(input logic [7:0] idx, output logic [7:0] v);
    logic [7:0] q;
    logic a;
    head(LDC_BUS_ADDR, idx, a);
    lines(1'b1, 1'b0, 3);
    lines(1'b1, 1'b1, 3);
    lines(1'b0, 1'b1, 2);
    xfer({LDC_BUS_ADDR, 1'b1}, 1'b1, q, a);
    xfer(8'hff, 1'b1, v, a);
    stop();
  endtask : rd
endmodule : ldc_host

// ===== tb/ldc_regs_properties.sv
// port checks for the led driver register bank
`timescale 1ns/1ps
module ldc_regs_properties
  import ldc_pkg::*;
#(
  parameter int COMP_SAT_SHORT_CYC = 20, // short trip length
  parameter int COMP_SAT_LONG_CYC = 40 // long trip length
)
(
  input wire logic clock, // clock
  input wire logic rst_n, // reset
  input wire logic sda_oe, // data pull
  input wire ldc_pkg::ldc_fault_events_t fault_events, // events
  input wire logic comp_saturated, // comp level
  input wire logic duty_above_2pct, // duty level
  input wire ldc_pkg::ldc_chan_cfg_t chan_cfg, // config
  input wire logic [5:0] channel_enable, // mask
  input wire logic all_short_protect_active, // armed
  input wire logic comp_sat_time_sel, // time select
  input wire logic led_ground_trip, // trip pulse
  input wire logic [5:0] fault_flags // sticky flags
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  int sat_cnt;
  int tgt;
  logic [2:0] code;
  logic [3:0] oe_hist;
  assign tgt = comp_sat_time_sel ? COMP_SAT_LONG_CYC - 1 : COMP_SAT_SHORT_CYC - 1;
  assign code = chan_cfg.active_channel_count;
  // saturation run length; a flag may only drop shortly after bus activity
  always_ff @(posedge clock)
  begin
    sat_cnt <= (!rst_n || !comp_saturated) ? 0 : sat_cnt + 1;
    oe_hist <= rst_n ? {oe_hist[2:0], sda_oe} : 4'h0;
  end
  AST_CHAN_DECODE: assert property (code < 3'h6 |-> channel_enable == 6'h3f >> code)
    else $error("channel mask wrong");
  AST_RESET_VAL: assert property ($rose(rst_n) |-> chan_cfg == LDC_CHAN_CFG_RESET
    && !comp_sat_time_sel && fault_flags == 6'h00) else $error("reset value wrong");
  AST_ALL_SHORT: assert property (all_short_protect_active |-> duty_above_2pct)
    else $error("armed at low duty");
  AST_EVENT_SET: assert property (fault_events != 5'h00 |=>
    (fault_flags[4:0] & $past(fault_events)) == $past(fault_events)) else $error("event lost");
  AST_GND_SET: assert property (led_ground_trip |=> fault_flags[5])
    else $error("ground trip lost");
  AST_TRIP_TIME: assert property (led_ground_trip |-> comp_saturated && sat_cnt == tgt)
    else $error("trip at wrong count");
  AST_TRIP_PULSE: assert property (led_ground_trip |=> !led_ground_trip)
    else $error("trip too long");
  AST_CLEAR_READ: assert property (($past(fault_flags) & ~fault_flags) != 6'h00 |->
    oe_hist != 4'h0) else $error("flag dropped without read");
  COV_TRIP: cover property (led_ground_trip);
  COV_ARMED: cover property (all_short_protect_active);
  COV_FLAGS: cover property (fault_flags[4:0] == 5'h1f);
endmodule : ldc_regs_properties
bind ldc_regs ldc_regs_properties #(.COMP_SAT_SHORT_CYC(COMP_SAT_SHORT_CYC),
  .COMP_SAT_LONG_CYC(COMP_SAT_LONG_CYC)) ldc_regs_properties_inst (.clock(clock),
  .rst_n(rst_n), .sda_oe(sda_oe), .fault_events(fault_events),
  .comp_saturated(comp_saturated), .duty_above_2pct(duty_above_2pct), .chan_cfg(chan_cfg),
  .channel_enable(channel_enable), .all_short_protect_active(all_short_protect_active),
  .comp_sat_time_sel(comp_sat_time_sel), .led_ground_trip(led_ground_trip),
  .fault_flags(fault_flags));

// ===== tb/tb.sv
// self-checking bench for the led driver register bank
`timescale 1ns/1ps
`define CHK(g, e) chk(8'(g), 8'(e))
module tb;
  import ldc_pkg::*;
  logic clock, rst_n, scl, sda_low, sda_oe, comp_saturated, duty_above_2pct, nak;
  logic all_short_protect_active, comp_sat_time_sel, led_ground_trip;
  ldc_fault_events_t fault_events;
  ldc_chan_cfg_t chan_cfg;
  logic [5:0] channel_enable, fault_flags;
  logic [7:0] rv, d;
  int n_errors = 0;
  int compares = 0;
  wire sda = !(sda_low || sda_oe); // pull-up when nobody pulls low
  ldc_regs #(.COMP_SAT_SHORT_CYC(20), .COMP_SAT_LONG_CYC(40)) ldc_regs_inst (.clock(clock),
    .rst_n(rst_n), .scl(scl), .sda_in(sda), .sda_out(), .sda_oe(sda_oe),
    .fault_events(fault_events), .comp_saturated(comp_saturated),
    .duty_above_2pct(duty_above_2pct), .chan_cfg(chan_cfg), .channel_enable(channel_enable),
    .all_short_protect_active(all_short_protect_active),
    .comp_sat_time_sel(comp_sat_time_sel), .led_ground_trip(led_ground_trip),
    .fault_flags(fault_flags));
  ldc_host ldc_host_inst (.clock(clock), .sda(sda), .scl(scl), .sda_low(sda_low));
  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  task automatic chk(input logic [7:0] g, e);
    compares++;
    if (g !== e)
    begin
      n_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic complete_run();
    $display("compares=%0d n_errors=%0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : complete_run
  task automatic w(input logic [7:0] i, v);
    ldc_host_inst.wr(LDC_BUS_ADDR, i, v, nak);
  endtask : w
  // hold the comp node saturated for n cycles, then let it recover
  task automatic sat(input int n);
    comp_saturated = 1'b1;
    repeat (n) @(negedge clock);
    comp_saturated = 1'b0;
    repeat (2) @(negedge clock);
  endtask : sat
  // watchdog well beyond the expected run length
  initial
  begin
    repeat (80000) @(posedge clock);
    n_errors++;
    complete_run();
  end
  initial
  begin
    rst_n = 1'b0;
    fault_events = '0;
    comp_saturated = 1'b0;
    duty_above_2pct = 1'b1;
    repeat (16) @(negedge clock);
    rst_n = 1'b1;
    @(negedge clock);
    `CHK(chan_cfg, LDC_CHAN_CFG_RESET);
    ldc_host_inst.rd(LDC_IDX_FAULT, rv);
    `CHK(rv, 8'h00);
    // every legal channel code, all threshold and frequency values
    for (int c = 0; c < 6; c++)
    begin
      d = {c[0], c[1:0], ~c[1:0], c[2:0]};
      w(LDC_IDX_CHAN_CFG, d);
      `CHK(nak, 1'b0);
      `CHK(channel_enable, 6'h3f >> c);
      ldc_host_inst.rd(LDC_IDX_CHAN_CFG, rv);
      `CHK(rv, d);
    end
    ldc_host_inst.wr(LDC_BUS_ADDR ^ 7'h01, LDC_IDX_CHAN_CFG, 8'h00, nak);
    `CHK(nak, 1'b1);
    `CHK(chan_cfg, d);
    w(LDC_IDX_IDENT, 8'h00);
    ldc_host_inst.rd(LDC_IDX_IDENT, rv);
    `CHK(rv, LDC_IDENT_DEFAULT);
    w(LDC_IDX_FAULT, 8'hff);
    `CHK({comp_sat_time_sel, all_short_protect_active}, 2'h3);
    duty_above_2pct = 1'b0;
    @(negedge clock);
    `CHK(all_short_protect_active, 1'b0);
    // one-cycle events accumulate as sticky flags
    for (int i = 0; i < 5; i++)
    begin
      fault_events = ldc_fault_events_t'(5'h01 << i);
      @(negedge clock);
      fault_events = '0;
      @(negedge clock);
      `CHK(fault_flags, 6'h3f >> (5 - i));
    end
    ldc_host_inst.rd(LDC_IDX_FAULT, rv);
    `CHK(rv, 8'hdf);
    ldc_host_inst.rd(LDC_IDX_FAULT, rv);
    `CHK(rv, 8'hc0);
    // one cycle short of the limit must not trip, the full limit must
    for (int s = 0; s < 2; s++)
    begin
      w(LDC_IDX_FAULT, {1'b0, s[0], 6'h00});
      sat(s ? 39 : 19);
      `CHK(fault_flags, 6'h00);
      sat(s ? 40 : 20);
      ldc_host_inst.rd(LDC_IDX_FAULT, rv);
      `CHK(rv, {1'b0, s[0], 6'h20});
      `CHK(fault_flags, 6'h00);
    end
    complete_run();
  end
endmodule : tb
